// ### logic/rpmc_axil.sv
// AXI4-Lite slave that turns bus transfers into register strobes.
`default_nettype none
`include "rpmc_params.svh"
module rpmc_axil import rpmc_pkg::*; (
  // Clock, reset and enable.
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // AXI4-Lite write channels.
  input wire logic [7:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  // AXI4-Lite read channels.
  input wire logic [7:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  // Register side.
  output logic wr_en_out,
  output logic [7:0] wr_addr_out,
  output logic [31:0] wr_data_out,
  output logic [3:0] wr_strb_out,
  input wire logic wr_ok_in,
  output logic rd_en_out,
  output logic [7:0] rd_addr_out,
  input wire logic rd_ok_in,
  input wire logic [31:0] rd_data_in
);

  rpmc_axil_t s_q;
  rpmc_axil_t s_d;
  logic wr_fire;
  logic rd_fire;

  // A write fires once address and data are both held and no answer is pending.
  assign wr_fire = s_q.aw_held && s_q.w_held && !s_q.bvalid;
  assign rd_fire = arvalid_in && s_q.arready;
  assign wr_en_out = wr_fire;
  assign wr_addr_out = s_q.awaddr;
  assign wr_data_out = s_q.wdata;
  assign wr_strb_out = s_q.wstrb;
  assign rd_en_out = rd_fire;
  assign rd_addr_out = araddr_in;

  // Channel handshakes; address and data are taken in either order.
  always_comb begin
    s_d = s_q;
    if (awvalid_in && s_q.awready) begin
      s_d.awaddr = awaddr_in;
      s_d.aw_held = 1'b1;
    end
    if (wvalid_in && s_q.wready) begin
      s_d.wdata = wdata_in;
      s_d.wstrb = wstrb_in;
      s_d.w_held = 1'b1;
    end
    if (s_q.bvalid && bready_in) begin
      s_d.bvalid = 1'b0;
    end
    if (wr_fire) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = wr_ok_in ? `RPMC_RESP_OKAY : `RPMC_RESP_SLVERR;
    end
    if (s_q.rvalid && rready_in) begin
      s_d.rvalid = 1'b0;
    end
    if (rd_fire) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_ok_in ? rd_data_in : 32'h0000_0000;
      s_d.rresp = rd_ok_in ? `RPMC_RESP_OKAY : `RPMC_RESP_SLVERR;
    end
    s_d.awready = !s_d.aw_held && !s_d.bvalid;
    s_d.wready = !s_d.w_held && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  assign awready_out = s_q.awready;
  assign wready_out = s_q.wready;
  assign bvalid_out = s_q.bvalid;
  assign bresp_out = s_q.bresp;
  assign arready_out = s_q.arready;
  assign rvalid_out = s_q.rvalid;
  assign rdata_out = s_q.rdata;
  assign rresp_out = s_q.rresp;

endmodule
`default_nettype wire

// ### logic/rpmc_flags.sv
// Reset source flags with their set and clear behaviour.
`default_nettype none
`include "rpmc_params.svh"
module rpmc_flags import rpmc_pkg::*; (
  // Clock, reset and enable.
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // One-cycle reset events, one per source.
  input wire logic [5:0] evt_in,
  // Software write of the flag register.
  input wire logic wr_en_in,
  input wire logic [5:0] wr_data_in,
  // Flag contents.
  output logic [5:0] flags_out
);

  rpmc_flags_t s_q;
  rpmc_flags_t s_d;

  // Power-on and watchdog resets replace the flags; others add to them.
  always_comb begin
    s_d = s_q;
    if (wr_en_in) begin
      s_d.flags = s_q.flags & wr_data_in;
    end
    if (evt_in[`RPMC_FLG_POF] || evt_in[`RPMC_FLG_WDT]) begin
      s_d.flags = `RPMC_FLG_PORWDT;
    end else begin
      s_d.flags = s_d.flags | evt_in;
    end
  end

  // Flags wake up as power-on so software sees the initial power-up.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q.flags <= `RPMC_FLG_RESET;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  assign flags_out = s_q.flags;

endmodule
`default_nettype wire

// ### logic/rpmc_params.svh
// Register offsets, field positions and reset values of the reset and power mode control block.
`ifndef RPMC_PARAMS_SVH
`define RPMC_PARAMS_SVH

// Byte offsets of the registers on the AXI4-Lite bus.
`define RPMC_OFS_CTRL 8'h00
`define RPMC_OFS_DROP_CFG 8'h04
`define RPMC_OFS_RESET_SRC 8'h08
`define RPMC_OFS_REGULATOR 8'h0C
`define RPMC_OFS_STATUS 8'h10

// Control register fields.
`define RPMC_CTRL_MODE_LO 0
`define RPMC_CTRL_IRQ_EN 2
`define RPMC_CTRL_WDT_PD 3
`define RPMC_CTRL_CMP_PD 4
`define RPMC_CTRL_ST_PD 5
`define RPMC_CTRL_SW_RST 7

// Reset source flag positions.
`define RPMC_FLG_EXT 0
`define RPMC_FLG_POF 1
`define RPMC_FLG_BOF 2
`define RPMC_FLG_WDT 3
`define RPMC_FLG_SW 4
`define RPMC_FLG_BRK 5
`define RPMC_FLG_N 6
`define RPMC_FLG_RESET 6'h06
`define RPMC_FLG_PORWDT 6'h06

// Regulator register fields.
`define RPMC_REG_LC 0
`define RPMC_REG_DONE 1

// Status register fields.
`define RPMC_ST_POWERUP 2
`define RPMC_ST_GPIO 3
`define RPMC_ST_FETCH_LO 16

// Bus answers.
`define RPMC_RESP_OKAY 2'h0
`define RPMC_RESP_SLVERR 2'h2

// Reset fetch address low byte and default address.
`define RPMC_BOOT_LOW 8'h00
`define RPMC_FETCH_ZERO 16'h0000

`endif

// ### logic/rpmc_pkg.sv
// Types shared by the reset and power mode control block.
`default_nettype none
package rpmc_pkg;

  // Power reduction mode of the core.
  typedef enum logic [1:0] {
    RPMC_NORMAL = 2'b00,
    RPMC_IDLE = 2'b01,
    RPMC_PD = 2'b10,
    RPMC_TPD = 2'b11
  } rpmc_mode_t;

  // State of the AXI4-Lite slave.
  typedef struct packed {
    logic [7:0] awaddr;
    logic aw_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_held;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rpmc_axil_t;

  // State of the reset source flags.
  typedef struct packed {
    logic [5:0] flags;
  } rpmc_flags_t;

  // State of the top level.
  typedef struct packed {
    rpmc_mode_t mode;
    logic irq_en;
    logic [2:0] irq_lvl;
    logic wdt_pd;
    logic cmp_pd;
    logic st_pd;
    logic lc;
    logic done;
    logic powerup;
    logic sw_rst;
    logic [5:0] cause_prev;
    logic sys_rst;
    logic drop_rst_en;
    logic drop_irq_en;
    logic drop_flash_en;
    logic flash_lock;
    logic drop_irq;
    logic osc_run;
    logic rc_run;
    logic cmp_run;
    logic wdt_run;
    logic st_run;
    logic cpu_clk_en;
    logic periph_clk_en;
    logic gpio_val;
    logic [15:0] fetch;
  } rpmc_top_t;

endpackage
`default_nettype wire

// ### logic/rpmc_top.sv
// Reset and power mode control: supply drop gating, power modes, regulator, reset flags and reset vector.
`default_nettype none
`include "rpmc_params.svh"
module rpmc_top import rpmc_pkg::*; (
  // Clock, reset and enable.
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // AXI4-Lite register bus.
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Supply detectors and reset sources.
  input wire logic power_on_detect_in,
  input wire logic drop_reset_trip_in,
  input wire logic drop_irq_trip_in,
  input wire logic drop_flash_trip_in,
  input wire logic watchdog_reset_in,
  input wire logic break_reset_in,
  // Shared reset pin and user configuration byte one fields.
  input wire logic shared_reset_pin_in,
  input wire logic reset_pin_enable_in,
  input wire logic [2:0] drop_reset_level_in,
  // Boot selection inputs.
  input wire logic boot_status_byte_bit0_in,
  input wire logic in_system_programming_force_in,
  input wire logic [7:0] boot_vector_in,
  // Wake sources, clock selection and regulator handshake.
  input wire logic irq_pending_in,
  input wire logic wake_irq_in,
  input wire logic rc_is_sysclk_in,
  input wire logic regulator_ready_in,
  // Supply drop detector controls.
  output logic drop_reset_en_out,
  output logic drop_irq_en_out,
  output logic drop_flash_en_out,
  output logic [2:0] drop_reset_level_out,
  output logic [2:0] drop_irq_level_out,
  output logic flash_lock_out,
  output logic drop_irq_out,
  // Clock and analog gating.
  output logic main_osc_run_out,
  output logic rc_osc_run_out,
  output logic comparator_run_out,
  output logic watchdog_run_out,
  output logic system_timer_run_out,
  output logic cpu_clk_en_out,
  output logic periph_clk_en_out,
  output logic low_current_select_out,
  // Reset results.
  output logic sys_reset_out,
  output logic shared_pin_value_out,
  output logic [15:0] fetch_addr_out,
  output logic [1:0] power_mode_out
);

  logic rst_sync1_q;
  logic rst_sync2_q;
  logic rst_n;
  rpmc_top_t s_q;
  rpmc_top_t s_d;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_byte0;
  logic rd_en;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic [5:0] flags;
  logic [5:0] cause;
  logic [5:0] evt;
  logic pin_rst;
  logic any_cause;
  logic awake;
  logic boot_sel;

  // Returns true for an offset that holds a register.
  function automatic logic reg_ok(input logic [7:0] addr);
    reg_ok = (addr == `RPMC_OFS_CTRL) || (addr == `RPMC_OFS_DROP_CFG) || (addr == `RPMC_OFS_RESET_SRC) ||
             (addr == `RPMC_OFS_REGULATOR) || (addr == `RPMC_OFS_STATUS);
  endfunction

  // Reset release through two flip-flops.
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync1_q <= 1'b0;
      rst_sync2_q <= 1'b0;
    end else begin
      rst_sync1_q <= 1'b1;
      rst_sync2_q <= rst_sync1_q;
    end
  end
  assign rst_n = rst_sync2_q;

  // Bus slave.
  rpmc_axil u_axil (
    .clk_in(clk_sys_in),
    .rst_n_in(rst_n),
    .ce_in(ce_in),
    .awaddr_in(s_axi_awaddr_in),
    .awvalid_in(s_axi_awvalid_in),
    .awready_out(s_axi_awready_out),
    .wdata_in(s_axi_wdata_in),
    .wstrb_in(s_axi_wstrb_in),
    .wvalid_in(s_axi_wvalid_in),
    .wready_out(s_axi_wready_out),
    .bresp_out(s_axi_bresp_out),
    .bvalid_out(s_axi_bvalid_out),
    .bready_in(s_axi_bready_in),
    .araddr_in(s_axi_araddr_in),
    .arvalid_in(s_axi_arvalid_in),
    .arready_out(s_axi_arready_out),
    .rdata_out(s_axi_rdata_out),
    .rresp_out(s_axi_rresp_out),
    .rvalid_out(s_axi_rvalid_out),
    .rready_in(s_axi_rready_in),
    .wr_en_out(wr_en),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data),
    .wr_strb_out(wr_strb),
    .wr_ok_in(reg_ok(wr_addr)),
    .rd_en_out(rd_en),
    .rd_addr_out(rd_addr),
    .rd_ok_in(reg_ok(rd_addr)),
    .rd_data_in(rd_data)
  );

  // All writable fields sit in byte lane 0, so only that strobe stores anything.
  assign wr_byte0 = wr_en && wr_strb[0];

  // Reset source flags.
  rpmc_flags u_flags (
    .clk_in(clk_sys_in),
    .rst_n_in(rst_n),
    .ce_in(ce_in),
    .evt_in(evt),
    .wr_en_in(wr_byte0 && (wr_addr == `RPMC_OFS_RESET_SRC)),
    .wr_data_in(wr_data[5:0]),
    .flags_out(flags)
  );

  // The pin resets while low if enabled, and always during power-up.
  assign pin_rst = !shared_reset_pin_in && (reset_pin_enable_in || s_q.powerup);
  assign awake = (s_q.mode == RPMC_NORMAL) || (s_q.mode == RPMC_IDLE);

  // Reset cause levels; the drop reset only acts while its detector is on.
  always_comb begin
    cause = '0;
    cause[`RPMC_FLG_EXT] = pin_rst && !s_q.powerup;
    cause[`RPMC_FLG_POF] = power_on_detect_in;
    cause[`RPMC_FLG_BOF] = drop_reset_trip_in && awake;
    cause[`RPMC_FLG_WDT] = watchdog_reset_in;
    cause[`RPMC_FLG_SW] = s_q.sw_rst;
    cause[`RPMC_FLG_BRK] = break_reset_in;
  end
  assign evt = cause & ~s_q.cause_prev;
  assign any_cause = (|cause) || pin_rst;
  assign boot_sel = break_reset_in || boot_status_byte_bit0_in ||
                    (s_q.powerup && in_system_programming_force_in);

  // Read data for the addressed register.
  always_comb begin
    rd_data = 32'h0000_0000;
    case (rd_addr)
      `RPMC_OFS_CTRL: begin
        rd_data[1:0] = s_q.mode;
        rd_data[`RPMC_CTRL_IRQ_EN] = s_q.irq_en;
        rd_data[`RPMC_CTRL_WDT_PD] = s_q.wdt_pd;
        rd_data[`RPMC_CTRL_CMP_PD] = s_q.cmp_pd;
        rd_data[`RPMC_CTRL_ST_PD] = s_q.st_pd;
      end
      `RPMC_OFS_DROP_CFG: begin
        rd_data[2:0] = s_q.irq_lvl;
      end
      `RPMC_OFS_RESET_SRC: begin
        rd_data[5:0] = flags;
      end
      `RPMC_OFS_REGULATOR: begin
        rd_data[`RPMC_REG_LC] = s_q.lc;
        rd_data[`RPMC_REG_DONE] = s_q.done;
      end
      `RPMC_OFS_STATUS: begin
        rd_data[1:0] = s_q.mode;
        rd_data[`RPMC_ST_POWERUP] = s_q.powerup;
        rd_data[`RPMC_ST_GPIO] = s_q.gpio_val;
        rd_data[31:16] = s_q.fetch;
      end
      default: begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  // Next state of the control logic.
  always_comb begin
    s_d = s_q;
    s_d.cause_prev = cause;
    s_d.sw_rst = 1'b0;
    // Power-up holds while the detector asserts and ends once the pin is high as well.
    if (power_on_detect_in) begin
      s_d.powerup = 1'b1;
    end else if (shared_reset_pin_in) begin
      s_d.powerup = 1'b0;
    end
    // Register writes; the mode field is taken only in normal mode.
    if (wr_byte0 && (wr_addr == `RPMC_OFS_CTRL)) begin
      s_d.irq_en = wr_data[`RPMC_CTRL_IRQ_EN];
      s_d.wdt_pd = wr_data[`RPMC_CTRL_WDT_PD];
      s_d.cmp_pd = wr_data[`RPMC_CTRL_CMP_PD];
      s_d.st_pd = wr_data[`RPMC_CTRL_ST_PD];
      s_d.sw_rst = wr_data[`RPMC_CTRL_SW_RST];
      if (s_q.mode == RPMC_NORMAL) begin
        s_d.mode = rpmc_mode_t'(wr_data[1:0]);
      end
    end
    if (wr_byte0 && (wr_addr == `RPMC_OFS_DROP_CFG)) begin
      s_d.irq_lvl = wr_data[2:0];
    end
    if (wr_byte0 && (wr_addr == `RPMC_OFS_REGULATOR)) begin
      s_d.lc = wr_data[`RPMC_REG_LC];
      if (s_q.lc && !wr_data[`RPMC_REG_LC]) begin
        s_d.done = 1'b0;
      end
    end
    // Completion reports once the regulator has settled in high speed.
    if (!s_q.done && !s_q.lc && regulator_ready_in) begin
      s_d.done = 1'b1;
    end
    // Wake-ups from the reduced modes.
    case (s_q.mode)
      RPMC_IDLE: begin
        if (irq_pending_in) begin
          s_d.mode = RPMC_NORMAL;
        end
      end
      RPMC_PD, RPMC_TPD: begin
        if (wake_irq_in) begin
          s_d.mode = RPMC_NORMAL;
        end
      end
      default: begin
      end
    endcase
    // Any reset returns to normal mode; power-on and watchdog restore high speed.
    if (any_cause) begin
      s_d.mode = RPMC_NORMAL;
      s_d.irq_en = 1'b0;
      s_d.wdt_pd = 1'b0;
      s_d.cmp_pd = 1'b0;
      s_d.st_pd = 1'b0;
      s_d.fetch = boot_sel ? {boot_vector_in, `RPMC_BOOT_LOW} : `RPMC_FETCH_ZERO;
    end
    if (evt[`RPMC_FLG_POF] || evt[`RPMC_FLG_WDT]) begin
      s_d.lc = 1'b0;
      s_d.done = 1'b1;
    end
    s_d.sys_rst = any_cause;
    // Gating derived from the mode that takes effect next.
    s_d.drop_rst_en = (s_d.mode == RPMC_NORMAL) || (s_d.mode == RPMC_IDLE);
    s_d.drop_flash_en = s_d.drop_rst_en;
    s_d.drop_irq_en = s_d.drop_rst_en && s_d.irq_en;
    s_d.flash_lock = s_d.drop_flash_en && drop_flash_trip_in;
    s_d.drop_irq = s_d.drop_irq_en && drop_irq_trip_in;
    s_d.osc_run = s_d.drop_rst_en;
    s_d.rc_run = s_d.drop_rst_en ||
                 ((s_d.mode == RPMC_PD) && rc_is_sysclk_in && !s_d.st_pd);
    s_d.cmp_run = s_d.drop_rst_en || ((s_d.mode == RPMC_PD) && !s_d.cmp_pd);
    s_d.wdt_run = !s_d.wdt_pd;
    s_d.st_run = !s_d.st_pd;
    s_d.cpu_clk_en = (s_d.mode == RPMC_NORMAL);
    s_d.periph_clk_en = s_d.drop_rst_en;
    s_d.gpio_val = (reset_pin_enable_in && !s_q.powerup) ? 1'b1 : shared_reset_pin_in;
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.mode <= RPMC_NORMAL;
      s_q.done <= 1'b1;
      s_q.powerup <= 1'b1;
      s_q.sys_rst <= 1'b1;
      s_q.drop_rst_en <= 1'b1;
      s_q.drop_flash_en <= 1'b1;
      s_q.osc_run <= 1'b1;
      s_q.rc_run <= 1'b1;
      s_q.cmp_run <= 1'b1;
      s_q.wdt_run <= 1'b1;
      s_q.st_run <= 1'b1;
      s_q.cpu_clk_en <= 1'b1;
      s_q.periph_clk_en <= 1'b1;
      s_q.gpio_val <= 1'b1;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register.
  assign drop_reset_en_out = s_q.drop_rst_en;
  assign drop_irq_en_out = s_q.drop_irq_en;
  assign drop_flash_en_out = s_q.drop_flash_en;
  assign flash_lock_out = s_q.flash_lock;
  assign drop_irq_out = s_q.drop_irq;
  assign drop_irq_level_out = s_q.irq_lvl;
  assign main_osc_run_out = s_q.osc_run;
  assign rc_osc_run_out = s_q.rc_run;
  assign comparator_run_out = s_q.cmp_run;
  assign watchdog_run_out = s_q.wdt_run;
  assign system_timer_run_out = s_q.st_run;
  assign cpu_clk_en_out = s_q.cpu_clk_en;
  assign periph_clk_en_out = s_q.periph_clk_en;
  assign low_current_select_out = s_q.lc;
  assign sys_reset_out = s_q.sys_rst;
  assign shared_pin_value_out = s_q.gpio_val;
  assign fetch_addr_out = s_q.fetch;
  assign power_mode_out = s_q.mode;

  // Reset trip level passes through a register of its own.
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      drop_reset_level_out <= 3'h0;
    end else if (ce_in) begin
      drop_reset_level_out <= drop_reset_level_in;
    end
  end

endmodule
`default_nettype wire

// ### tb/rpmc_chk.sv
// Assertions on power mode gating and reset outcomes of the top module.
`default_nettype none
module rpmc_chk (
  // Clock, reset and watched inputs.
  input wire logic clk_sys_in, rstn_in, rc_is_sysclk_in, break_reset_in, watchdog_reset_in,
  input wire logic shared_reset_pin_in, reset_pin_enable_in,
  input wire logic [7:0] boot_vector_in,
  // Watched outputs.
  input wire logic drop_reset_en_out, drop_irq_en_out, drop_flash_en_out, main_osc_run_out,
  input wire logic rc_osc_run_out, comparator_run_out, periph_clk_en_out, sys_reset_out,
  input wire logic [15:0] fetch_addr_out,
  input wire logic [1:0] power_mode_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  // Gating of supply drop functions and clocks follows the mode.
  AST_PD_DROP: assert property (power_mode_out[1] |-> !(drop_reset_en_out | drop_irq_en_out | drop_flash_en_out))
    else $error("drop function on in power-down");
  AST_RUN_DROP: assert property (!power_mode_out[1] |-> drop_reset_en_out && drop_flash_en_out)
    else $error("drop reset or flash guard off while running");
  AST_PD_OSC: assert property (power_mode_out[1] |-> !main_osc_run_out)
    else $error("main oscillator runs in power-down");
  AST_PD_RC: assert property (power_mode_out == 2'h2 && rc_osc_run_out |-> $past(rc_is_sysclk_in))
    else $error("rc oscillator runs without being system clock");
  AST_TPD: assert property (power_mode_out == 2'h3 |-> !comparator_run_out && !rc_osc_run_out)
    else $error("analog kept alive in total power-down");
  AST_IDLE: assert property (power_mode_out == 2'h1 |-> periph_clk_en_out)
    else $error("peripherals stopped in idle");
  // Reset causes act on the next edge and pick the fetch address.
  AST_WDT: assert property ($rose(watchdog_reset_in) |=> sys_reset_out && power_mode_out == 2'h0)
    else $error("watchdog did not reset");
  AST_PIN: assert property ($fell(shared_reset_pin_in) && reset_pin_enable_in |=> sys_reset_out)
    else $error("enabled pin did not reset");
  AST_BOOT: assert property ($rose(break_reset_in) |-> ##[1:3] fetch_addr_out == {boot_vector_in, 8'h00})
    else $error("break reset did not pick boot address");
endmodule
bind rpmc_top rpmc_chk u_chk (.*);
`default_nettype wire

// ### tb/rpmc_pin_model.sv
// Board-side model of the shared reset pin with its pull-up.
`default_nettype none
module rpmc_pin_model (
  // Clock and pull-low request.
  input wire logic clk_in,
  input wire logic pull_low_in,
  // Pin level seen by the device.
  output logic pin_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // A released pin returns to the pull-up level at the next edge.
  initial pin_out = 1'b1;
  always @(posedge clk_in) pin_out <= !pull_low_in;
endmodule
`default_nettype wire

// ### tb/tb_reset_and_power_mode_control.sv
// Self-checking bench of the reset and power mode control block.
`default_nettype none
`include "rpmc_params.svh"
module tb_reset_and_power_mode_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rstn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic reset_pin_enable = 1, itrip = 0, ftrip = 0, rrdy = 0, pin, awr, wrr, bv, arr, rv;
  logic dien, fl, dirq, osc, rc, lc, srst, pinv, wdr, stm, cpe, bst = 0;
  logic [1:0] wk = 0, rs_q, rresp, mode, bs_q, bresp;
  logic [4:0] src = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [2:0] dlvl = 0, dil, drl;
  logic [31:0] wdata = 0, rd_q, rdata, exp;
  int fb[3] = '{0, 2, 5};
  int err_count = 0, n_compared = 0;
  // Clock of 50 ns period.
  initial forever #25 clk = !clk;
  rpmc_pin_model u_pin (.clk_in(clk), .pull_low_in(src[0]), .pin_out(pin));
  rpmc_top DUT (.clk_sys_in(clk), .rstn_in(rstn), .ce_in(1'b1),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrr), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(rready), .power_on_detect_in(src[4]), .drop_reset_trip_in(src[1]),
    .drop_irq_trip_in(itrip), .drop_flash_trip_in(ftrip), .watchdog_reset_in(src[3]),
    .break_reset_in(src[2]), .shared_reset_pin_in(pin), .reset_pin_enable_in(reset_pin_enable),
    .drop_reset_level_in(dlvl), .boot_status_byte_bit0_in(bst), .in_system_programming_force_in(1'b0),
    .boot_vector_in(8'hA5), .irq_pending_in(wk[0]), .wake_irq_in(wk[1]), .rc_is_sysclk_in(1'b1),
    .regulator_ready_in(rrdy), .drop_reset_en_out(), .drop_irq_en_out(dien), .drop_flash_en_out(),
    .drop_reset_level_out(drl), .drop_irq_level_out(dil), .flash_lock_out(fl), .drop_irq_out(dirq),
    .main_osc_run_out(osc), .rc_osc_run_out(rc), .comparator_run_out(), .watchdog_run_out(wdr),
    .system_timer_run_out(stm), .cpu_clk_en_out(cpe), .periph_clk_en_out(), .low_current_select_out(lc),
    .sys_reset_out(srst), .shared_pin_value_out(pinv), .fetch_addr_out(), .power_mode_out(mode));
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    n_compared++;
    if (got !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Bus write: both channels offered together, each released when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrr) wv <= 1'b0;
    end while (!bv);
    bs_q = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask
  // Bus read followed by a compare of the data.
  task automatic rck(input logic [7:0] a, input logic [31:0] e);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rready <= 1'b0;
    rd_q = rdata;
    rs_q = rresp;
    chk(rd_q, e);
    @(posedge clk);
  endtask
  task automatic hit(input int i);
    src[i] <= 1'b1;
    wt(3);
    src[i] <= 1'b0;
    wt(4);
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Hang guard.
  initial begin
    #200000;
    err_count++;
    results();
  end
  // Test sequence.
  initial begin
    wt(8);
    rstn <= 1'b1;
    wt(4);
    rck(`RPMC_OFS_RESET_SRC, 32'h06);
    wr(`RPMC_OFS_RESET_SRC, 32'h3B);
    chk(bs_q, `RPMC_RESP_OKAY);
    rck(`RPMC_OFS_RESET_SRC, 32'h02);
    wr(`RPMC_OFS_RESET_SRC, 32'h0);
    exp = 0;
    foreach (fb[i]) begin
      hit(i);
      exp |= 32'h1 << fb[i];
      rck(`RPMC_OFS_RESET_SRC, exp);
    end
    rck(`RPMC_OFS_STATUS, {16'hA500, 16'h0008});
    wr(`RPMC_OFS_CTRL, 32'h80);
    wt(3);
    rck(`RPMC_OFS_RESET_SRC, 32'h35);
    rck(`RPMC_OFS_STATUS, 32'h8);
    bst <= 1'b1;
    hit(0);
    rck(`RPMC_OFS_STATUS, 32'hA500_0008);
    bst <= 1'b0;
    hit(3);
    rck(`RPMC_OFS_RESET_SRC, 32'h06);
    $display("flag test done");
    wr(`RPMC_OFS_RESET_SRC, 32'h0);
    reset_pin_enable <= 1'b0;
    src[0] <= 1'b1;
    wt(1);
    hit(4);
    chk(srst, 1'b1);
    src[0] <= 1'b0;
    wt(4);
    chk(srst, 1'b0);
    rck(`RPMC_OFS_RESET_SRC, 32'h06);
    src[0] <= 1'b1;
    wt(3);
    chk({srst, pinv}, 2'b00);
    src[0] <= 1'b0;
    wt(2);
    reset_pin_enable <= 1'b1;
    $display("power-up test done");
    for (int m = 1; m < 4; m++) begin
      wr(`RPMC_OFS_CTRL, 32'(m));
      wt(2);
      chk({mode, osc, rc, cpe}, {m[1:0], m == 1, m != 3, 1'b0});
      wk[m > 1] <= 1'b1;
      wt(2);
      wk <= 2'b00;
      wt(2);
      chk({mode, cpe}, 3'h1);
    end
    $display("mode test done");
    wr(`RPMC_OFS_CTRL, 32'h04);
    wr(`RPMC_OFS_DROP_CFG, 32'h05);
    itrip <= 1'b1;
    ftrip <= 1'b1;
    dlvl <= 3'h3;
    wt(3);
    chk({dien, dirq, dil, drl, fl}, {2'b11, 3'h5, 3'h3, 1'b1});
    itrip <= 1'b0;
    ftrip <= 1'b0;
    $display("drop test done");
    wr(`RPMC_OFS_CTRL, 32'h38);
    chk({wdr, stm}, 2'b00);
    wr(`RPMC_OFS_CTRL, 32'h22);
    chk({rc, wdr, stm}, 3'b010);
    wk[1] <= 1'b1;
    wt(2);
    wk <= 2'b00;
    wt(1);
    wr(`RPMC_OFS_REGULATOR, 32'h1);
    chk(lc, 1'b1);
    wr(`RPMC_OFS_REGULATOR, 32'h0);
    rck(`RPMC_OFS_REGULATOR, 32'h0);
    rrdy <= 1'b1;
    wt(3);
    rck(`RPMC_OFS_REGULATOR, 32'h2);
    rck(8'h40, 32'h0);
    chk(rs_q, `RPMC_RESP_SLVERR);
    wr(8'h40, 32'h1);
    chk(bs_q, `RPMC_RESP_SLVERR);
    $display("regulator and bus test done");
    results();
  end
endmodule
`default_nettype wire
